// ---- shared/angr_map.svh ----
// Offsets, field positions, reset values and timing for the AN register bank
`ifndef ANGR_MAP_SVH
`define ANGR_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ANGR_OFS_ADV   5'h04
`define ANGR_OFS_LPAB  5'h05
`define ANGR_OFS_EXP   5'h06
`define ANGR_OFS_NPTX  5'h07
`define ANGR_OFS_LPNP  5'h08
`define ANGR_OFS_GIG   5'h09

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define ANGR_ADV_RST   16'h01E1
`define ANGR_ADV_WMASK 16'hBFFF
`define ANGR_NPTX_RST  16'h2001
`define ANGR_NPTX_WMASK 16'hB7FF
`define ANGR_GIG_RST   16'h0300
`define ANGR_GIG_WMASK 16'hFF00
`define ANGR_LP_RST    16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define ANGR_NP_BIT    15
`define ANGR_TOG_BIT   11
`define ANGR_TM_HI     15
`define ANGR_TM_LO     13
`define ANGR_MS_MAN    12
`define ANGR_MS_VAL    11
`define ANGR_PORT_MP   10
`define ANGR_G_FD      9
`define ANGR_G_HD      8

// ****************************************************************
// Test mode codes
// ****************************************************************
`define ANGR_TM_NORMAL 3'h0
`define ANGR_TM_LAST   3'h4

// ****************************************************************
// Soft reset hold-off
// ****************************************************************
`define ANGR_SRST_US   1
`define ANGR_CLK_MHZ   100

`endif

// ---- shared/angr_pkg.sv ----
// Types shared by the AN register bank modules
package angr_pkg;

  typedef struct packed {
    logic        q;
  } angr_flag_t;

  typedef struct packed {
    logic [15:0] adv;
    logic [15:0] lp_ab;
    logic [15:0] np_tx;
    logic [15:0] lp_np;
    logic [15:0] gig;
    logic        np_tog;
    logic [15:0] rdata;
    logic        rvalid;
    logic [7:0]  busy_cnt;
    logic        busy;
    logic [2:0]  tm_eff;
    logic        ms_master;
    logic        ms_slave;
  } angr_state_t;

endpackage

// ---- shared/angr_flag_if.sv ----
// Set, clear and state of one latched-high status flag
interface angr_flag_if;
  logic set;
  logic clr;
  logic q;
  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface

// ---- hw/angr_sticky.sv ----
// Latched-high flag: set wins over a clear in the same cycle
module angr_sticky
  import angr_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_n,
  angr_flag_if.owner  flag
);

  angr_flag_t st;
  angr_flag_t next_st;

  always_comb begin
    next_st   = st;
    next_st.q = flag.set | (st.q & ~flag.clr);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag.q = st.q;

endmodule

// ---- hw/angr_regs.sv ----
// Auto-negotiation and gigabit control register bank, offsets 4 to 9
// Functional notes
// RULE1 - Advertisement at 0x04: 16 bits, resets 0x01E1 with selector 00001
// RULE2 - Bit 15 next-page request, bit 13 remote fault writable; 14 reserved
// RULE3 - Bits 11 and 10 advertise asymmetric and symmetric pause, reset 0
// RULE4 - Ability bits writable; bit 9 resets 0, bits 8 to 5 reset 1
// RULE5 - Partner ability at 0x05 is read-only, selector resets 00000
// RULE6 - Partner bits 11 and 10 report partner pause abilities, reset 0
// RULE7 - Expansion bit 4 latches parallel detection fault until cleared
// RULE8 - Expansion bit 1 latches when a new page arrives
// RULE9 - Expansion bit 2 always reads 1; bits 15 to 5 read 0
// RULE10 - Bit 3 partner next-page able, bit 0 partner autoneg able
// RULE11 - Next-page transmit at 0x07: writable fields, resets 0x2001
// RULE12 - Transmit bit 11 reads inverse of last sent word's toggle
// RULE13 - Partner next page at 0x08 read-only, resets zero
// RULE14 - Partner next-page bit 12 reads 1 when partner complies
// RULE15 - Gigabit bits 15:13 select test mode; codes 5 to 7 reserved
// RULE16 - Test modes follow the standard 1000BASE-T transmitter tests
// RULE17 - Gigabit bit 12 enables manual master/slave, reset 0
// RULE18 - Bit 11 chooses master or slave only while bit 12 set
// RULE19 - Gigabit bit 10 declares multi-port or single-port, reset 0
// RULE20 - Bits 9 and 8 advertise gigabit duplex, reset 1; 7:0 read 0
// RULE21 - Soft reset restores defaults; host waits 1 us before access
// RULE22 - Host sets master/slave role before forcing gigabit speed
// RULE23 - Engine sends current words and loads partner words on receipt
// RULE24 - Reading the expansion register clears the latched flags
`include "angr_map.svh"

module angr_regs
  import angr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        soft_rst,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  output logic             busy,
  input  wire logic        an_page_rx,
  input  wire logic        an_rx_base,
  input  wire logic [15:0] an_rx_word,
  input  wire logic        an_pd_fault,
  input  wire logic        an_lp_an_able,
  input  wire logic        an_lcw_sent,
  input  wire logic        an_lcw_toggle,
  output logic      [15:0] adv_word,
  output logic      [15:0] np_tx_word,
  output logic      [2:0]  tx_test_mode,
  output logic             ms_manual,
  output logic             ms_force_master,
  output logic             ms_force_slave,
  output logic             port_multi,
  output logic             adv_1000fd,
  output logic             adv_1000hd
);

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SRST_CYC = `ANGR_SRST_US * `ANGR_CLK_MHZ;
  localparam logic [7:0] SRST_CNT = 8'(SRST_CYC);

  angr_state_t st;
  angr_state_t next_st;

  angr_flag_if pdf_flag ();
  angr_flag_if page_flag ();

  logic        acc_ok;
  logic        wr_go;
  logic        rd_go;
  logic [15:0] exp_word;
  logic [15:0] rd_mux;

  // ****************************************************************
  // Latched expansion flags
  // ****************************************************************
  angr_sticky u_pdf (
    .mclk  (mclk),
    .rst_n (rst_n),
    .flag  (pdf_flag)
  );

  angr_sticky u_page (
    .mclk  (mclk),
    .rst_n (rst_n),
    .flag  (page_flag)
  );

  // Accesses during the reset hold-off are dropped, not queued
  assign acc_ok = !st.busy && !soft_rst;
  assign wr_go  = acc_ok && reg_wr;
  assign rd_go  = acc_ok && reg_rd;

  assign pdf_flag.set  = an_pd_fault; // [RULE7]
  assign page_flag.set = an_page_rx; // [RULE8]
  // Read clears; a same-cycle event still wins in the flag itself
  assign pdf_flag.clr  = soft_rst ||
                         (rd_go && reg_addr == `ANGR_OFS_EXP); // [RULE24]
  assign page_flag.clr = pdf_flag.clr; // [RULE24]

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    exp_word    = 16'h0000; // [RULE9]
    exp_word[4] = pdf_flag.q; // [RULE7]
    exp_word[3] = st.lp_ab[`ANGR_NP_BIT]; // [RULE10]
    exp_word[2] = 1'b1; // [RULE9]
    exp_word[1] = page_flag.q; // [RULE8]
    exp_word[0] = an_lp_an_able; // [RULE10]
  end

  always_comb begin
    case (reg_addr)
      `ANGR_OFS_ADV:  rd_mux = st.adv;
      `ANGR_OFS_LPAB: rd_mux = st.lp_ab; // [RULE6]
      `ANGR_OFS_EXP:  rd_mux = exp_word;
      `ANGR_OFS_NPTX: rd_mux = {st.np_tx[15:12], st.np_tog,
                                st.np_tx[10:0]}; // [RULE12]
      `ANGR_OFS_LPNP: rd_mux = st.lp_np; // [RULE14]
      `ANGR_OFS_GIG:  rd_mux = st.gig;
      default:        rd_mux = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    if (st.busy_cnt != 8'h00) begin
      next_st.busy_cnt = st.busy_cnt - 8'h01;
    end
    if (wr_go) begin
      case (reg_addr)
        `ANGR_OFS_ADV: begin
          next_st.adv = reg_wdata & `ANGR_ADV_WMASK; // [RULE2] [RULE3]
        end
        `ANGR_OFS_NPTX: begin
          next_st.np_tx = reg_wdata & `ANGR_NPTX_WMASK; // [RULE11]
        end
        `ANGR_OFS_GIG: begin
          next_st.gig = reg_wdata & `ANGR_GIG_WMASK; // [RULE20]
        end
        default: begin
          // Partner and expansion words ignore writes
          next_st.gig = next_st.gig; // [RULE5] [RULE13]
        end
      endcase
    end
    if (rd_go) begin
      next_st.rdata  = rd_mux;
      next_st.rvalid = 1'b1;
    end
    if (an_page_rx) begin
      if (an_rx_base) begin
        next_st.lp_ab = an_rx_word; // [RULE23]
      end else begin
        next_st.lp_np = an_rx_word; // [RULE23]
      end
    end
    if (an_lcw_sent) begin
      next_st.np_tog = ~an_lcw_toggle; // [RULE12]
    end
    if (soft_rst) begin
      next_st.adv      = `ANGR_ADV_RST; // [RULE21]
      next_st.lp_ab    = `ANGR_LP_RST;
      next_st.np_tx    = `ANGR_NPTX_RST;
      next_st.lp_np    = `ANGR_LP_RST;
      next_st.gig      = `ANGR_GIG_RST;
      next_st.np_tog   = 1'b0;
      next_st.busy_cnt = SRST_CNT; // [RULE21]
    end
    next_st.busy = (next_st.busy_cnt != 8'h00);
    // Reserved test codes fall back to normal transmission
    if (next_st.gig[`ANGR_TM_HI:`ANGR_TM_LO] > `ANGR_TM_LAST) begin
      next_st.tm_eff = `ANGR_TM_NORMAL; // [RULE15]
    end else begin
      next_st.tm_eff = next_st.gig[`ANGR_TM_HI:`ANGR_TM_LO]; // [RULE16]
    end
    next_st.ms_master = next_st.gig[`ANGR_MS_MAN] &
                        next_st.gig[`ANGR_MS_VAL]; // [RULE18]
    next_st.ms_slave  = next_st.gig[`ANGR_MS_MAN] &
                        ~next_st.gig[`ANGR_MS_VAL]; // [RULE18]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st           <= '0;
      st.adv       <= `ANGR_ADV_RST; // [RULE1] [RULE4]
      st.np_tx     <= `ANGR_NPTX_RST; // [RULE11]
      st.gig       <= `ANGR_GIG_RST; // [RULE17] [RULE19]
      st.lp_ab     <= `ANGR_LP_RST; // [RULE5]
      st.lp_np     <= `ANGR_LP_RST; // [RULE13]
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs, all from flops
  // ****************************************************************
  assign reg_rdata       = st.rdata;
  assign reg_rvalid      = st.rvalid;
  assign busy            = st.busy;
  assign adv_word        = st.adv; // [RULE23]
  assign np_tx_word      = {st.np_tx[15:12], st.np_tog, st.np_tx[10:0]};
  assign tx_test_mode    = st.tm_eff;
  assign ms_manual       = st.gig[`ANGR_MS_MAN]; // [RULE17]
  assign ms_force_master = st.ms_master;
  assign ms_force_slave  = st.ms_slave;
  assign port_multi      = st.gig[`ANGR_PORT_MP]; // [RULE19]
  assign adv_1000fd      = st.gig[`ANGR_G_FD];
  assign adv_1000hd      = st.gig[`ANGR_G_HD];

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_adv_reset_val: assert property ( // [RULE1]
    @(posedge mclk) !rst_n |=> adv_word == 16'h01E1)
    else $error("advertisement reset value wrong");

  a_adv_bit14_zero: assert property ( // [RULE2]
    @(posedge mclk) disable iff (!rst_n) adv_word[14] == 1'b0)
    else $error("advertisement bit 14 not zero");

  a_adv_pause_wr: assert property ( // [RULE3]
    @(posedge mclk) disable iff (!rst_n)
    wr_go && reg_addr == 5'h04 |=>
      adv_word[11:10] == $past(reg_wdata[11:10]))
    else $error("pause bits not written");

  a_partner_ro: assert property ( // [RULE5]
    @(posedge mclk) disable iff (!rst_n)
    wr_go && reg_addr == 5'h05 && !an_page_rx && !soft_rst |=>
      $stable(st.lp_ab))
    else $error("partner ability changed by write");

  a_pdf_latch: assert property ( // [RULE7]
    @(posedge mclk) disable iff (!rst_n)
    an_pd_fault |=> pdf_flag.q)
    else $error("fault flag not latched");

  a_page_latch: assert property ( // [RULE8]
    @(posedge mclk) disable iff (!rst_n)
    an_page_rx ##1 !pdf_flag.clr [*2] |=> page_flag.q)
    else $error("page flag not held");

  a_exp_fixed: assert property ( // [RULE9]
    @(posedge mclk) disable iff (!rst_n)
    rd_go && reg_addr == 5'h06 |=>
      reg_rvalid && reg_rdata[2] && reg_rdata[15:5] == 11'h000)
    else $error("expansion fixed bits wrong");

  a_toggle_inv: assert property ( // [RULE12]
    @(posedge mclk) disable iff (!rst_n)
    an_lcw_sent && !soft_rst |=>
      np_tx_word[11] == !$past(an_lcw_toggle))
    else $error("toggle bit not inverted");

  a_test_mode_ok: assert property ( // [RULE15]
    @(posedge mclk) disable iff (!rst_n)
    tx_test_mode <= 3'h4 &&
    (st.gig[15:13] <= 3'h4 || tx_test_mode == 3'h0))
    else $error("reserved test mode passed on");

  a_ms_gated: assert property ( // [RULE18]
    @(posedge mclk) disable iff (!rst_n)
    (ms_force_master || ms_force_slave) |->
      ms_manual && (ms_force_master == st.gig[11]))
    else $error("master/slave not gated by manual");

  a_srst_holdoff: assert property ( // [RULE21]
    @(posedge mclk) disable iff (!rst_n)
    soft_rst |=> busy && adv_word == 16'h01E1 ##100 !busy)
    else $error("soft reset hold-off wrong");

  a_exp_rd_clr: assert property ( // [RULE24]
    @(posedge mclk) disable iff (!rst_n)
    rd_go && reg_addr == 5'h06 && !an_pd_fault |=> !pdf_flag.q)
    else $error("fault flag not cleared by read");

endmodule

// ---- tb/angr_host.sv ----
// Management host model driving the register strobe port
module angr_host (
  input  wire logic        mclk,
  input  wire logic        busy,
  input  wire logic        reg_rvalid,
  input  wire logic [15:0] reg_rdata,
  output logic             soft_rst,
  output logic      [4:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    soft_rst  = 1'b0;
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  // Accesses during the hold-off would be dropped, so wait it out
  task automatic idle();
    int n;
    n = 0;
    @(negedge mclk);
    while (busy !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    idle();
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    idle();
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    // A missing answer must never match an expected value
    if (reg_rvalid === 1'b1) begin
      d = reg_rdata;
    end else begin
      d = 16'hxxxx;
    end
  endtask

  // Write with no hold-off wait, to show refused accesses
  task automatic poke(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
  endtask

  task automatic srst();
    @(negedge mclk);
    soft_rst = 1'b1;
    @(negedge mclk);
    soft_rst = 1'b0;
  endtask
endmodule

// ---- tb/test_autoneg_gigabit_control_regs.sv ----
// Self-checking bench for the AN and gigabit control register bank
module test_autoneg_gigabit_control_regs;
  import angr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        w;
    logic [4:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } angr_row_t;

  logic mclk, rst_n, soft_rst, reg_wr, reg_rd, reg_rvalid, busy;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, an_rx_word, adv_word, np_tx_word, got;
  logic an_page_rx, an_rx_base, an_pd_fault, an_lp_an_able;
  logic an_lcw_sent, an_lcw_toggle, ms_manual, ms_force_master;
  logic ms_force_slave, port_multi, adv_1000fd, adv_1000hd;
  logic [2:0] tx_test_mode;
  int bad_count, total_checks;

  // Reset values, then masks of writable bits per address
  angr_row_t rows [15] = '{
    '{1'b0, 5'h04, 16'h0000, 16'h01E1}, '{1'b0, 5'h05, 16'h0000, 16'h0000},
    '{1'b0, 5'h06, 16'h0000, 16'h0004}, '{1'b0, 5'h07, 16'h0000, 16'h2001},
    '{1'b0, 5'h08, 16'h0000, 16'h0000}, '{1'b0, 5'h09, 16'h0000, 16'h0300},
    '{1'b1, 5'h04, 16'hFFFF, 16'hBFFF}, '{1'b1, 5'h04, 16'h0000, 16'h0000},
    '{1'b1, 5'h05, 16'hFFFF, 16'h0000}, '{1'b1, 5'h06, 16'hFFFF, 16'h0004},
    '{1'b1, 5'h07, 16'hFFFF, 16'hB7FF}, '{1'b1, 5'h08, 16'hFFFF, 16'h0000},
    '{1'b1, 5'h09, 16'hFFFF, 16'hFF00}, '{1'b1, 5'h09, 16'h0000, 16'h0000},
    '{1'b1, 5'h1F, 16'hFFFF, 16'h0000}};
  logic [15:0] gw [4] = '{16'h1300, 16'h0800, 16'h0C00, 16'h1B00};
  logic [5:0]  ge [4] = '{6'b101011, 6'b000000, 6'b000100, 6'b110011};

  angr_regs dut (.mclk(mclk), .rst_n(rst_n), .soft_rst(soft_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .busy(busy), .an_page_rx(an_page_rx), .an_rx_base(an_rx_base),
    .an_rx_word(an_rx_word), .an_pd_fault(an_pd_fault),
    .an_lp_an_able(an_lp_an_able), .an_lcw_sent(an_lcw_sent),
    .an_lcw_toggle(an_lcw_toggle), .adv_word(adv_word),
    .np_tx_word(np_tx_word), .tx_test_mode(tx_test_mode),
    .ms_manual(ms_manual), .ms_force_master(ms_force_master),
    .ms_force_slave(ms_force_slave), .port_multi(port_multi),
    .adv_1000fd(adv_1000fd), .adv_1000hd(adv_1000hd));

  angr_host host (.mclk(mclk), .busy(busy), .reg_rvalid(reg_rvalid),
    .reg_rdata(reg_rdata), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ev(input logic pg, base, pd, sent, tog,
                    input logic [15:0] w);
    @(negedge mclk);
    {an_page_rx, an_rx_base, an_pd_fault, an_lcw_sent} = {pg, base, pd, sent};
    {an_lcw_toggle, an_rx_word} = {tog, w};
    @(negedge mclk);
    {an_page_rx, an_pd_fault, an_lcw_sent} = 3'b000;
    @(negedge mclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run needs a few hundred cycles; the 10000-cycle limit allows ample margin
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    {an_page_rx, an_rx_base, an_pd_fault, an_lcw_sent} = 4'h0;
    {an_lp_an_able, an_lcw_toggle, an_rx_word} = 18'h0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 15; i++) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, got);
      if (i < 6) begin
        chk(got, rows[i].e);
      end else begin
        chk(got, rows[i].e);
      end
    end
    $display("table test done");
    for (int c = 0; c < 8; c++) begin
      host.wr(5'h09, {c[2:0], 13'h1800});
      @(negedge mclk);
      chk(tx_test_mode, (c > 4) ? 3'h0 : c[2:0]);
    end
    // Role is settled here before any forced gigabit speed
    for (int i = 0; i < 4; i++) begin
      host.wr(5'h09, gw[i]);
      @(negedge mclk);
      chk({ms_manual, ms_force_master, ms_force_slave, port_multi,
           adv_1000fd, adv_1000hd}, ge[i]);
    end
    $display("gigabit control test done");
    an_lp_an_able = 1'b1;
    ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h8C01);
    host.rd(5'h05, got);
    chk(got, 16'h8C01);
    host.rd(5'h06, got);
    chk(got, 16'h000F);
    host.rd(5'h06, got);
    chk(got, 16'h000D);
    ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h5ABC);
    host.rd(5'h08, got);
    chk(got, 16'h5ABC);
    host.rd(5'h06, got);
    chk(got, 16'h001F);
    host.rd(5'h06, got);
    chk(got, 16'h000D);
    ev(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0000);
    chk(np_tx_word, 16'hB7FF);
    ev(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk(np_tx_word, 16'hBFFF);
    $display("engine test done");
    host.wr(5'h04, 16'hFFFF);
    host.srst();
    chk(busy, 1'b1);
    // Write during the hold-off must be dropped
    host.poke(5'h04, 16'hFFFF);
    host.rd(5'h04, got);
    chk(got, 16'h01E1);
    host.rd(5'h08, got);
    chk(got, 16'h0000);
    host.rd(5'h06, got);
    chk(got, 16'h0005);
    $display("soft reset test done");
    host.wr(5'h09, 16'h0000);
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    host.rd(5'h09, got);
    chk(got, 16'h0300);
    chk(adv_word, 16'h01E1);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
